// ==== rtl/ivc_params.svh ====
`ifndef IVC_PARAMS_SVH
`define IVC_PARAMS_SVH

// exception codes and handler addresses
`define IVC_CODE_RESET          16'h0000
`define IVC_CODE_NMI            16'h0010
`define IVC_CODE_WDTA_NMI       16'h0020
`define IVC_CODE_WDTB_NMI       16'h0030
`define IVC_CODE_TRAP_LOW_BASE  12'h004
`define IVC_CODE_TRAP_HIGH_BASE 12'h005
`define IVC_HANDLER_TRAP_LOW    32'h00000040
`define IVC_HANDLER_TRAP_HIGH   32'h00000050
`define IVC_CODE_EXC_TRAP       16'h0060
`define IVC_MASKABLE_BASE       16'h0080

// source counts
`define IVC_SOURCES_BASE        55
`define IVC_SOURCES_WITH_TWI    57
`define IVC_NONMASKABLE_COUNT   3
`define IVC_MASKABLE_COUNT      54
`define IVC_PRIO_W              6
`define IVC_PIN_COUNT           8
`define IVC_TRAP_NUM_W          5
`define IVC_TRAP_GROUP_BIT      4

// maskable slots, indexed by default priority
`define IVC_PRIO_WDTA_INTERVAL  6'h00
`define IVC_PRIO_PIN_FIRST      6'h01
`define IVC_PRIO_TMR00_A        6'h08
`define IVC_PRIO_TMR00_B        6'h09
`define IVC_PRIO_TWI_A          6'h19
`define IVC_PRIO_PIN7           6'h34
`define IVC_PRIO_TWI_B          6'h35
`define IVC_GENERIC_SLOTS       54'h2FFFFFFFFFFC00

// request classes, one-hot bit positions, lowest bit wins
`define IVC_CLS_RESET           0
`define IVC_CLS_NMI             1
`define IVC_CLS_WDTA            2
`define IVC_CLS_WDTB            3
`define IVC_CLS_EXC             4
`define IVC_CLS_TRAP            5
`define IVC_CLS_MASK            6
`define IVC_CLS_W               7

`endif

// ==== rtl/ivc_pkg.sv ====
`default_nettype none
`include "ivc_params.svh"

package ivc_pkg;

	typedef enum logic [1:0] {
		IVC_IDLE    = 2'b01,
		IVC_PRESENT = 2'b10
	} ivc_state_t;

	typedef logic [`IVC_PRIO_W-1:0] ivc_prio_t;

	// set wins over clear
	function automatic logic ivc_pend_next(input logic flag, input logic set, input logic clr);
		return set | (flag & ~clr);
	endfunction

	function automatic logic [15:0] ivc_maskable_code(input ivc_prio_t prio);
		return `IVC_MASKABLE_BASE + {6'h00, prio, 4'h0};
	endfunction

	function automatic logic [31:0] ivc_handler_of(input logic [15:0] code);
		return {16'h0000, code};
	endfunction

endpackage

`default_nettype wire

// ==== rtl/ivc_edge_detect.sv ====
`timescale 1ns/1ps
`default_nettype none

module ivc_edge_detect #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// pins
	input  wire logic [WIDTH-1:0] level,
	input  wire logic [WIDTH-1:0] fall_sel,
	// one-cycle edge hits
	output logic      [WIDTH-1:0] hit
);

	logic [WIDTH-1:0] prev;
	wire  [WIDTH-1:0] rising  = level & ~prev;
	wire  [WIDTH-1:0] falling = ~level & prev;

	// a pin already high at reset release counts as a rising edge
	always_ff @(posedge clk) begin
		if (rst)
			prev <= '0;
		else
			prev <= level;
	end

	assign hit = (rising & ~fall_sel) | (falling & fall_sel);

endmodule

`default_nettype wire

// ==== rtl/ivc_prio_pick.sv ====
`timescale 1ns/1ps
`default_nettype none

module ivc_prio_pick #(
	parameter int WIDTH = 54,
	parameter int IDX_W = 6
) (
	// requests, bit 0 most urgent
	input  wire logic [WIDTH-1:0] req,
	// winner
	output logic                  any,
	output logic      [IDX_W-1:0] idx
);

	always_comb begin
		idx = '0;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			if (req[i])
				idx = IDX_W'(i);
		end
	end

	assign any = |req;

endmodule

`default_nettype wire

// ==== rtl/ivc_irq_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ivc_params.svh"
// How it works
// R1: accepts 55 sources, or 57 when the two-wire serial variant is built.
// R2: pin or watchdog reset vectors with code 0000H, handler 0, no resume point.
// R3: valid NMI pin edge gives code 0010H, handler 10H, resumes at next instruction.
// R4: watchdog A overflow in NMI mode gives code 0020H, handler 20H.
// R5: watchdog B overflow in NMI mode gives code 0030H, handler 30H.
// R6: low soft trap group gives code 004nH, shared handler 40H, resumes next.
// R7: high soft trap group gives code 005nH, shared handler 50H, resumes next.
// R8: illegal opcode or debug trap instruction gives code 0060H, resumes next.
// R9: watchdog A overflow in interval mode is maskable priority 0, code 0080H.
// R10: eight external pins are edge detected; pins 0-6 take priority 1-7.
// R11: maskable handler address is the exception code zero-extended to 32 bits.
// R12: timer 00 compare A is priority 8 code 0100H; compare B priority 9 code 0110H.
// R13: among pending maskable requests the smallest priority number goes first.

module ivc_irq_controller
	import ivc_pkg::*;
#(
	parameter bit HAS_TWO_WIRE = 1'b1
) (
	// clock and reset
	input  wire logic                            clk,
	input  wire logic                            rst,
	// reset and non-maskable sources
	input  wire logic                            reset_pin_req,
	input  wire logic                            watchdog_a_reset,
	input  wire logic                            watchdog_b_reset,
	input  wire logic                            nmi_pin,
	input  wire logic                            nmi_edge_fall,
	input  wire logic                            watchdog_a_overflow,
	input  wire logic                            watchdog_a_nmi_mode,
	input  wire logic                            watchdog_b_overflow,
	input  wire logic                            watchdog_b_nmi_mode,
	// exceptions from the core
	input  wire logic                            soft_trap_req,
	input  wire logic [`IVC_TRAP_NUM_W-1:0]      soft_trap_number,
	input  wire logic                            illegal_opcode_trap,
	input  wire logic                            debug_trap_instruction,
	// maskable sources
	input  wire logic [`IVC_PIN_COUNT-1:0]       ext_pin_irq,
	input  wire logic [`IVC_PIN_COUNT-1:0]       ext_pin_edge_fall,
	input  wire logic                            timer00_compare_a_irq,
	input  wire logic                            timer00_compare_b_irq,
	input  wire logic [`IVC_MASKABLE_COUNT-1:0]  periph_irq,
	input  wire logic [`IVC_MASKABLE_COUNT-1:0]  irq_enable,
	input  wire logic                            cpu_irq_enable,
	// cpu side
	output logic                                 cpu_req_valid,
	input  wire logic                            cpu_ack,
	output logic      [15:0]                     cpu_req_code,
	output logic      [31:0]                     cpu_req_handler,
	output logic                                 cpu_req_resume_next,
	output logic      [`IVC_CLS_W-1:0]           cpu_req_class,
	output ivc_prio_t                            cpu_req_prio
);

	localparam int SOURCE_COUNT = HAS_TWO_WIRE ? `IVC_SOURCES_WITH_TWI : `IVC_SOURCES_BASE;
	localparam logic [`IVC_MASKABLE_COUNT-1:0] ONE = `IVC_MASKABLE_COUNT'(1);

	ivc_state_t state;
	ivc_state_t next_state;

	logic                           reset_pend;
	logic                           nmi_pend;
	logic                           wdta_pend;
	logic                           wdtb_pend;
	logic                           exc_pend;
	logic                           trap_pend;
	logic [`IVC_TRAP_NUM_W-1:0]     trap_num;
	logic [`IVC_MASKABLE_COUNT-1:0] mask_pend;

	logic                           nmi_hit;
	logic [`IVC_PIN_COUNT-1:0]      pin_hit;
	logic                           mask_any;
	ivc_prio_t                      pick_idx;

	ivc_edge_detect #(.WIDTH(1)) u_nmi_edge (
		.clk      (clk),
		.rst      (rst),
		.level    (nmi_pin),
		.fall_sel (nmi_edge_fall),
		.hit      (nmi_hit)
	);

	// all eight pins are edge triggered
	ivc_edge_detect #(.WIDTH(`IVC_PIN_COUNT)) u_pin_edge ( // R10
		.clk      (clk),
		.rst      (rst),
		.level    (ext_pin_irq),
		.fall_sel (ext_pin_edge_fall),
		.hit      (pin_hit)
	);

	// event decode
	wire reset_event = reset_pin_req | watchdog_a_reset | watchdog_b_reset; // R2
	wire wdta_nmi_ev = watchdog_a_overflow & watchdog_a_nmi_mode; // R4
	wire wdtb_nmi_ev = watchdog_b_overflow & watchdog_b_nmi_mode; // R5
	wire wdta_int_ev = watchdog_a_overflow & ~watchdog_a_nmi_mode; // R9
	wire exc_event   = illegal_opcode_trap | debug_trap_instruction; // R8

	// the two-wire slots vanish on the smaller variant
	wire [`IVC_MASKABLE_COUNT-1:0] twi_slots    = (ONE << `IVC_PRIO_TWI_A) | (ONE << `IVC_PRIO_TWI_B);
	wire [`IVC_MASKABLE_COUNT-1:0] present_mask = HAS_TWO_WIRE ? ~'0 : ~twi_slots; // R1

	wire [`IVC_MASKABLE_COUNT-1:0] wired_event =
		(`IVC_MASKABLE_COUNT'(wdta_int_ev) << `IVC_PRIO_WDTA_INTERVAL) | // R9
		(`IVC_MASKABLE_COUNT'(pin_hit[`IVC_PIN_COUNT-2:0]) << `IVC_PRIO_PIN_FIRST) | // R10
		(`IVC_MASKABLE_COUNT'(pin_hit[`IVC_PIN_COUNT-1]) << `IVC_PRIO_PIN7) |
		(`IVC_MASKABLE_COUNT'(timer00_compare_a_irq) << `IVC_PRIO_TMR00_A) | // R12
		(`IVC_MASKABLE_COUNT'(timer00_compare_b_irq) << `IVC_PRIO_TMR00_B); // R12

	wire [`IVC_MASKABLE_COUNT-1:0] mask_set = (wired_event | (periph_irq & `IVC_GENERIC_SLOTS)) & present_mask;

	// pending stays latched while masked; only the pick is gated
	wire [`IVC_MASKABLE_COUNT-1:0] eligible = mask_pend & irq_enable & present_mask &
		{`IVC_MASKABLE_COUNT{cpu_irq_enable}};

	ivc_prio_pick #(.WIDTH(`IVC_MASKABLE_COUNT), .IDX_W(`IVC_PRIO_W)) u_pick ( // R13
		.req (eligible),
		.any (mask_any),
		.idx (pick_idx)
	);

	// class arbitration: isolate lowest set bit
	wire [`IVC_CLS_W-1:0] class_req  = {mask_any, trap_pend, exc_pend, wdtb_pend, wdta_pend, nmi_pend, reset_pend};
	wire [`IVC_CLS_W-1:0] class_pick = class_req & (~class_req + `IVC_CLS_W'(1));
	wire                  class_any  = |class_req;

	wire                 trap_high = trap_num[`IVC_TRAP_GROUP_BIT];
	wire [3:0]           trap_low  = trap_num[`IVC_TRAP_GROUP_BIT-1:0];
	wire [15:0]          trap_code = {trap_high ? `IVC_CODE_TRAP_HIGH_BASE : `IVC_CODE_TRAP_LOW_BASE, trap_low}; // R6 R7
	wire [31:0]          trap_hdlr = trap_high ? `IVC_HANDLER_TRAP_HIGH : `IVC_HANDLER_TRAP_LOW; // R6 R7

	wire [15:0] next_code =
		class_pick[`IVC_CLS_RESET] ? `IVC_CODE_RESET : // R2
		class_pick[`IVC_CLS_NMI]   ? `IVC_CODE_NMI : // R3
		class_pick[`IVC_CLS_WDTA]  ? `IVC_CODE_WDTA_NMI : // R4
		class_pick[`IVC_CLS_WDTB]  ? `IVC_CODE_WDTB_NMI : // R5
		class_pick[`IVC_CLS_EXC]   ? `IVC_CODE_EXC_TRAP : // R8
		class_pick[`IVC_CLS_TRAP]  ? trap_code :
		ivc_maskable_code(pick_idx); // R9 R10 R12

	// traps share one handler per group; all others derive it from the code
	wire [31:0] next_handler = class_pick[`IVC_CLS_TRAP] ? trap_hdlr : ivc_handler_of(next_code); // R11
	// reset has no resume point; watchdog NMIs restore by their own recovery path
	wire next_resume = ~(class_pick[`IVC_CLS_RESET] | class_pick[`IVC_CLS_WDTA] | class_pick[`IVC_CLS_WDTB]);

	wire take     = (state == IVC_IDLE) && class_any;
	wire ack_done = (state == IVC_PRESENT) && cpu_ack;
	wire [`IVC_CLS_W-1:0]         clr_cls  = ack_done ? cpu_req_class : '0;
	wire [`IVC_MASKABLE_COUNT-1:0] clr_mask = (ack_done && cpu_req_class[`IVC_CLS_MASK]) ?
		(ONE << cpu_req_prio) : '0;

	always_comb begin
		case (state)
			IVC_IDLE:    next_state = class_any ? IVC_PRESENT : IVC_IDLE;
			IVC_PRESENT: next_state = cpu_ack ? IVC_IDLE : IVC_PRESENT;
			default:     next_state = IVC_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			state <= IVC_IDLE;
		else
			state <= next_state;
	end

	// pending flags: a new event in the clearing cycle survives
	always_ff @(posedge clk) begin
		if (rst) begin
			reset_pend <= 1'b0;
			nmi_pend   <= 1'b0;
			wdta_pend  <= 1'b0;
			wdtb_pend  <= 1'b0;
			exc_pend   <= 1'b0;
			trap_pend  <= 1'b0;
			mask_pend  <= '0;
		end else begin
			reset_pend <= ivc_pend_next(reset_pend, reset_event, clr_cls[`IVC_CLS_RESET]); // R2
			nmi_pend   <= ivc_pend_next(nmi_pend, nmi_hit, clr_cls[`IVC_CLS_NMI]); // R3
			wdta_pend  <= ivc_pend_next(wdta_pend, wdta_nmi_ev, clr_cls[`IVC_CLS_WDTA]); // R4
			wdtb_pend  <= ivc_pend_next(wdtb_pend, wdtb_nmi_ev, clr_cls[`IVC_CLS_WDTB]); // R5
			exc_pend   <= ivc_pend_next(exc_pend, exc_event, clr_cls[`IVC_CLS_EXC]); // R8
			trap_pend  <= ivc_pend_next(trap_pend, soft_trap_req, clr_cls[`IVC_CLS_TRAP]);
			mask_pend  <= mask_set | (mask_pend & ~clr_mask);
		end
	end

	// a second trap before acknowledge overwrites the number; the core issues one at a time
	always_ff @(posedge clk) begin
		if (rst)
			trap_num <= '0;
		else if (soft_trap_req)
			trap_num <= soft_trap_number;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_req_code        <= 16'h0000;
			cpu_req_handler     <= 32'h00000000;
			cpu_req_resume_next <= 1'b0;
			cpu_req_class       <= '0;
			cpu_req_prio        <= '0;
		end else if (take) begin
			cpu_req_code        <= next_code;
			cpu_req_handler     <= next_handler;
			cpu_req_resume_next <= next_resume;
			cpu_req_class       <= class_pick;
			cpu_req_prio        <= pick_idx;
		end
	end

	assign cpu_req_valid = (state == IVC_PRESENT);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_SOURCE_COUNT: assert property ( // R1
		$countones(present_mask) == SOURCE_COUNT - `IVC_NONMASKABLE_COUNT)
		else $error("maskable slot count does not match variant");

	AST_RESET_VECTOR: assert property ( // R2
		reset_event && !reset_pend && class_req == '0 && state == IVC_IDLE |=> ##1
		cpu_req_valid && cpu_req_class[`IVC_CLS_RESET] && cpu_req_code == `IVC_CODE_RESET &&
		cpu_req_handler == 32'h00000000 && !cpu_req_resume_next)
		else $error("reset request not vectored to zero");

	AST_NMI_VECTOR: assert property ( // R3
		cpu_req_valid && cpu_req_class[`IVC_CLS_NMI] |->
		cpu_req_code == `IVC_CODE_NMI && cpu_req_handler == 32'h00000010 && cpu_req_resume_next)
		else $error("nmi vector wrong");

	AST_NMI_LATCH: assert property ( // R3
		$rose(nmi_pin) && !nmi_edge_fall |=> nmi_pend)
		else $error("nmi edge not latched");

	AST_WDTA_NMI: assert property ( // R4
		wdta_nmi_ev |=> wdta_pend && !mask_pend[`IVC_PRIO_WDTA_INTERVAL] ||
		$past(mask_pend[`IVC_PRIO_WDTA_INTERVAL]))
		else $error("watchdog A nmi routed wrong");

	AST_WDTB_VECTOR: assert property ( // R5
		cpu_req_valid && cpu_req_class[`IVC_CLS_WDTB] |->
		cpu_req_code == `IVC_CODE_WDTB_NMI && cpu_req_handler == 32'h00000030)
		else $error("watchdog B nmi vector wrong");

	AST_TRAP_VECTOR: assert property ( // R6
		soft_trap_req && soft_trap_number == 5'h03 && class_req == '0 && state == IVC_IDLE &&
		!(reset_event | nmi_hit | wdta_nmi_ev | wdtb_nmi_ev | exc_event) |=> ##1
		cpu_req_valid && cpu_req_code == 16'h0043 && cpu_req_handler == 32'h00000040 && cpu_req_resume_next)
		else $error("low trap vector wrong");

	AST_TRAP_HIGH: assert property ( // R7
		cpu_req_valid && cpu_req_class[`IVC_CLS_TRAP] && cpu_req_code[15:4] == `IVC_CODE_TRAP_HIGH_BASE |->
		cpu_req_handler == 32'h00000050)
		else $error("high trap handler wrong");

	AST_EXC_VECTOR: assert property ( // R8
		cpu_req_valid && cpu_req_class[`IVC_CLS_EXC] |->
		cpu_req_code == `IVC_CODE_EXC_TRAP && cpu_req_resume_next)
		else $error("exception trap vector wrong");

	AST_WDTA_INTERVAL: assert property ( // R9
		wdta_int_ev |=> mask_pend[`IVC_PRIO_WDTA_INTERVAL])
		else $error("watchdog A interval request lost");

	AST_PIN_EDGE: assert property ( // R10
		$rose(ext_pin_irq[2]) && !ext_pin_edge_fall[2] |=> mask_pend[3])
		else $error("pin edge not latched at its priority");

	AST_MASK_HANDLER: assert property ( // R11
		cpu_req_valid && cpu_req_class[`IVC_CLS_MASK] |->
		cpu_req_handler == {16'h0000, cpu_req_code} && cpu_req_code == 16'h0080 + {6'h00, cpu_req_prio, 4'h0})
		else $error("maskable handler or code wrong");

	AST_TIMER_SLOT: assert property ( // R12
		timer00_compare_b_irq |=> mask_pend[9])
		else $error("timer compare B request lost");

	AST_LOWEST_FIRST: assert property ( // R13
		take && class_pick[`IVC_CLS_MASK] |=>
		cpu_req_prio == $past(pick_idx) && ($past(eligible) & ((ONE << cpu_req_prio) - ONE)) == '0)
		else $error("maskable pick not the most urgent");

	AST_ACK_DROPS: assert property (
		cpu_req_valid && cpu_ack |=> !cpu_req_valid ##1 (cpu_req_valid == $past(class_any)))
		else $error("valid not released after acknowledge");

	COV_MASK_SERVED: cover property (cpu_req_valid && cpu_ack && cpu_req_class[`IVC_CLS_MASK]);
	COV_NMI_SERVED:  cover property (cpu_req_valid && cpu_ack && cpu_req_class[`IVC_CLS_NMI]);
	COV_TRAP_SERVED: cover property (cpu_req_valid && cpu_ack && cpu_req_class[`IVC_CLS_TRAP]);
	COV_SET_AT_CLR:  cover property (ack_done && cpu_req_class[`IVC_CLS_MASK] && mask_set[cpu_req_prio]);

endmodule

`default_nettype wire

// ==== verif/ivc_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ivc_cpu_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// vector from the controller
	input  wire logic        cpu_req_valid,
	input  wire logic [15:0] cpu_req_code,
	input  wire logic [31:0] cpu_req_handler,
	input  wire logic        cpu_req_resume_next,
	input  wire logic [6:0]  cpu_req_class,
	input  wire logic [5:0]  cpu_req_prio,
	// pacing and handshake
	input  wire logic [3:0]  ack_delay,
	output logic             cpu_ack,
	// what was taken, for the bench
	output logic [15:0]      takes,
	output logic [15:0]      got_code,
	output logic [31:0]      got_handler,
	output logic             got_resume,
	output logic [6:0]       got_class,
	output logic [5:0]       got_prio
);
	logic [3:0] wait_cnt;

	// ack rises just after an edge and is held until the edge that takes the vector
	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_ack  <= 1'b0;
			wait_cnt <= 4'h0;
			takes    <= 16'h0000;
		end else if (cpu_req_valid && cpu_ack) begin
			got_code    <= cpu_req_code;
			got_handler <= cpu_req_handler;
			got_resume  <= cpu_req_resume_next;
			got_class   <= cpu_req_class;
			got_prio    <= cpu_req_prio;
			takes       <= takes + 16'h0001;
			cpu_ack     <= 1'b0;
			wait_cnt    <= 4'h0;
		end else if (cpu_req_valid) begin
			if (wait_cnt >= ack_delay) begin
				cpu_ack <= 1'b1;
			end else begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
	end
endmodule

`default_nettype wire

// ==== verif/ivc_irq_controller_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module ivc_irq_controller_bench;
	import ivc_pkg::*;
	logic clk = 1'b0, rst = 1'b1;
	logic rp = 1'b0, wa_rst = 1'b0, wb_rst = 1'b0, nmi = 1'b0, nmi_fall = 1'b0;
	logic wa_ovf = 1'b0, wa_nmi = 1'b1, wb_ovf = 1'b0, wb_nmi = 1'b1;
	logic st_req = 1'b0, ill = 1'b0, dbg = 1'b0, tm_a = 1'b0, tm_b = 1'b0, gie = 1'b1;
	logic [4:0] st_num = 5'h00;
	logic [7:0] pins = 8'h00, pin_fall = 8'h80;
	logic [53:0] periph = '0, ien = '1;
	logic [3:0] ack_delay = 4'h1;
	logic valid, ack, resume, g_res;
	logic [15:0] code, takes, g_code;
	logic [31:0] hnd, g_hnd;
	logic [6:0] cls, g_cls;
	logic [5:0] prio, g_prio;
	int errors = 0, checks_done = 0, used = 0, s1, s2;

	always #50 clk = ~clk;

	ivc_irq_controller #(.HAS_TWO_WIRE(1'b1)) ivc_irq_controller_i (.clk(clk), .rst(rst),
		.reset_pin_req(rp), .watchdog_a_reset(wa_rst), .watchdog_b_reset(wb_rst), .nmi_pin(nmi),
		.nmi_edge_fall(nmi_fall), .watchdog_a_overflow(wa_ovf), .watchdog_a_nmi_mode(wa_nmi),
		.watchdog_b_overflow(wb_ovf), .watchdog_b_nmi_mode(wb_nmi), .soft_trap_req(st_req),
		.soft_trap_number(st_num), .illegal_opcode_trap(ill), .debug_trap_instruction(dbg),
		.ext_pin_irq(pins), .ext_pin_edge_fall(pin_fall), .timer00_compare_a_irq(tm_a),
		.timer00_compare_b_irq(tm_b), .periph_irq(periph), .irq_enable(ien), .cpu_irq_enable(gie),
		.cpu_req_valid(valid), .cpu_ack(ack), .cpu_req_code(code), .cpu_req_handler(hnd),
		.cpu_req_resume_next(resume), .cpu_req_class(cls), .cpu_req_prio(prio));

	ivc_cpu_model ivc_cpu_model_i (.clk(clk), .rst(rst), .cpu_req_valid(valid), .cpu_req_code(code),
		.cpu_req_handler(hnd), .cpu_req_resume_next(resume), .cpu_req_class(cls), .cpu_req_prio(prio),
		.ack_delay(ack_delay), .cpu_ack(ack), .takes(takes), .got_code(g_code), .got_handler(g_hnd),
		.got_resume(g_res), .got_class(g_cls), .got_prio(g_prio));

	task automatic stop_test;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [15:0] mcode(input int slot);
		return 16'h0080 + 16'(slot * 16);
	endfunction

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// waits for the core to take the next vector, then compares its fields, the priority only when chk_prio is set
	task automatic expect_take(input logic [15:0] c, input logic [31:0] h, input logic [6:0] k,
			input logic [5:0] p, input logic r, input bit chk_prio);
		int n;
		n = 0;
		while (takes == 16'(used) && n < 80) begin
			tick(1);
			n++;
		end
		// a vector that never comes must not pass on the fields of the previous one
		check(takes, 16'(used + 1));
		used++;
		check(g_code, c);
		check(g_handler_fix(g_hnd), h);
		check(g_cls, k);
		check(g_res, r);
		if (chk_prio)
			check(g_prio, p);
	endtask

	function automatic logic [31:0] g_handler_fix(input logic [31:0] v);
		return v;
	endfunction

	task automatic expect_mask(input int slot);
		expect_take(mcode(slot), {16'h0000, mcode(slot)}, 7'h40, 6'(slot), 1'b1, 1'b1);
	endtask

	// nothing may be taken for a while
	task automatic expect_quiet;
		tick(20);
		check(takes, 16'(used));
	endtask

	initial begin
		void'($urandom(12672));
		tick(5);
		rst = 1'b0;
		tick(1);
		rp = 1'b1; tick(1); rp = 1'b0;
		expect_take(16'h0000, 32'h00000000, 7'h01, 6'h00, 1'b0, 1'b0);
		wa_rst = 1'b1; tick(1); wa_rst = 1'b0;
		expect_take(16'h0000, 32'h00000000, 7'h01, 6'h00, 1'b0, 1'b0);
		wb_rst = 1'b1; tick(1); wb_rst = 1'b0;
		expect_take(16'h0000, 32'h00000000, 7'h01, 6'h00, 1'b0, 1'b0);
		nmi = 1'b1; tick(3);
		expect_take(16'h0010, 32'h00000010, 7'h02, 6'h00, 1'b1, 1'b0);
		nmi_fall = 1'b1; tick(3); nmi = 1'b0;
		expect_take(16'h0010, 32'h00000010, 7'h02, 6'h00, 1'b1, 1'b0);
		nmi_fall = 1'b0;
		expect_quiet();
		wa_ovf = 1'b1; tick(1); wa_ovf = 1'b0;
		expect_take(16'h0020, 32'h00000020, 7'h04, 6'h00, 1'b0, 1'b0);
		wb_ovf = 1'b1; tick(1); wb_ovf = 1'b0;
		expect_take(16'h0030, 32'h00000030, 7'h08, 6'h00, 1'b0, 1'b0);
		wb_nmi = 1'b0; wb_ovf = 1'b1; tick(1); wb_ovf = 1'b0;
		expect_quiet();
		wa_nmi = 1'b0; wa_ovf = 1'b1; tick(1); wa_ovf = 1'b0;
		expect_mask(0);
		for (int t = 0; t < 32; t++) begin
			ack_delay = 4'($urandom % 8);
			st_num = 5'(t); st_req = 1'b1; tick(1); st_req = 1'b0;
			if (t < 16)
				expect_take({12'h004, 4'(t)}, 32'h00000040, 7'h20, 6'h00, 1'b1, 1'b0);
			else
				expect_take({12'h005, 4'(t)}, 32'h00000050, 7'h20, 6'h00, 1'b1, 1'b0);
		end
		ill = 1'b1; tick(1); ill = 1'b0;
		expect_take(16'h0060, 32'h00000060, 7'h10, 6'h00, 1'b1, 1'b0);
		dbg = 1'b1; tick(1); dbg = 1'b0;
		expect_take(16'h0060, 32'h00000060, 7'h10, 6'h00, 1'b1, 1'b0);
		for (int i = 0; i < 7; i++) begin
			pins[i] = 1'b1; tick(3);
			expect_mask(i + 1);
			pins[i] = 1'b0;
		end
		expect_quiet();
		pins[7] = 1'b1; tick(3);
		expect_quiet();
		pins[7] = 1'b0;
		expect_mask(52);
		tm_a = 1'b1; tick(1); tm_a = 1'b0;
		expect_mask(8);
		ien[9] = 1'b0; tm_b = 1'b1; tick(1); tm_b = 1'b0;
		expect_quiet();
		ien[9] = 1'b1; gie = 1'b0;
		expect_quiet();
		gie = 1'b1;
		expect_mask(9);
		// simultaneous maskables come out lowest slot first
		ack_delay = 4'h6;
		tm_b = 1'b1; tm_a = 1'b1; pins[2] = 1'b1; tick(1); tm_a = 1'b0; tm_b = 1'b0;
		expect_mask(3);
		expect_mask(8);
		expect_mask(9);
		pins[2] = 1'b0;
		// class order beats maskable order
		tm_a = 1'b1; st_num = 5'h13; st_req = 1'b1; ill = 1'b1; nmi = 1'b1; tick(1);
		tm_a = 1'b0; st_req = 1'b0; ill = 1'b0;
		expect_take(16'h0010, 32'h00000010, 7'h02, 6'h00, 1'b1, 1'b0);
		expect_take(16'h0060, 32'h00000060, 7'h10, 6'h00, 1'b1, 1'b0);
		expect_take(16'h0053, 32'h00000050, 7'h20, 6'h00, 1'b1, 1'b0);
		expect_mask(8);
		nmi = 1'b0;
		for (int k = 0; k < 30; k++) begin
			s1 = 10 + int'($urandom % 43);
			s2 = 10 + int'($urandom % 43);
			if (s1 == 52) s1 = 53;
			if (s2 == 52 || s2 == s1) s2 = (s1 == 53) ? 10 : 53;
			ack_delay = 4'($urandom % 8);
			periph[s1] = 1'b1; periph[s2] = 1'b1; tick(1); periph = '0;
			expect_mask(s1 < s2 ? s1 : s2);
			expect_mask(s1 < s2 ? s2 : s1);
		end
		stop_test();
	end

	initial begin
		tick(20000);
		errors++;
		$display("mismatch at %0t: run did not finish", $time);
		stop_test();
	end
endmodule

`default_nettype wire
